/* design/fewc_regs.svh */
// offsets, field positions, reset values and counts of the flash sequencer
`ifndef FEWC_REGS_SVH
`define FEWC_REGS_SVH
`define FEWC_TRIG_OFS 8'h94
`define FEWC_CTL_OFS 8'hB2
`define FEWC_PAGE_OFS 8'hB7
`define FEWC_PAGE_RST 8'h00
`define FEWC_CODE_MASS 8'hAA
`define FEWC_CODE_PAGE 8'h55
`define FEWC_PWE_BIT 0
`define FEWC_MEEN_BIT 1
`define FEWC_PROT_BIT 6
`define FEWC_PAGE_BYTES 512
`define FEWC_PAGES 128
`define FEWC_ERASED 8'hFF
`define FEWC_WR_CYCLES 4
`define FEWC_DIV_FLASH 8'h0C
`define FEWC_DIV_RST 8'h00
`define FEWC_RESET_PC 16'h0000
`define FEWC_VEC_BASE 16'h0003
`define FEWC_VEC_STEP 16'h0008
`define FEWC_CODE_TOP 16'h7FFF
`define FEWC_SFR_BASE 8'h80
`define FEWC_BITRAM_BASE 8'h20
`endif

/* design/fewc_pkg.sv */
// types and address decoding shared by both ends
`include "fewc_regs.svh"
package fewc_pkg;
    typedef enum logic [3:0] {
        DS_IDLE = 4'h1,
        DS_PAGE = 4'h2,
        DS_MASS = 4'h4,
        DS_WRITE = 4'h8
    } fewc_dstate_t;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_ST1 = 5'h02,
        HS_ST2 = 5'h04,
        HS_GAP = 5'h08,
        HS_WAIT = 5'h10
    } fewc_hstate_t;

    typedef enum logic [3:0] {
        OP_DIV = 4'h0,
        OP_PAGE = 4'h1,
        OP_MASS = 4'h2,
        OP_WRITE = 4'h3,
        OP_RSFR = 4'h4,
        OP_FETCH = 4'h5,
        OP_VEC = 4'h6,
        OP_INTERNAL_DATA_RAM = 4'h7,
        OP_WSFR = 4'h8
    } fewc_op_t;

    // vector n sits at base plus n times the spacing
    function automatic logic [15:0] fewc_vec_addr(input logic [7:0] n);
        return 16'(`FEWC_VEC_BASE + 16'(n) * `FEWC_VEC_STEP);
    endfunction

    // mode 0 direct, 1 indirect, 2 bank register, 3 bit; {sfr, byte}
    function automatic logic [8:0] fewc_internal_data_ram_map(input logic [1:0] mode,
        input logic [7:0] a, input logic [1:0] bank);
        logic [8:0] r;
        r = {1'b0, a};
        case (mode)
            2'd0: r = {a >= `FEWC_SFR_BASE, a};
            2'd1: r = {1'b0, a};
            2'd2: r = {1'b0, 3'b000, bank, a[2:0]};
            default: begin
                if (a[7]) begin
                    r = {1'b1, a[7:3], 3'b000};
                end else begin
                    r = {1'b0, `FEWC_BITRAM_BASE + {4'h0, a[6:3]}};
                end
            end
        endcase
        return r;
    endfunction
endpackage

/* design/fewc_if.sv */
// special function register, store and code bus between core and flash
`timescale 1ns/1ns
interface fewc_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic st_wr;
    logic [15:0] st_addr;
    logic [7:0] st_data;
    logic [15:0] code_addr;
    logic [7:0] code_rdata;
    logic ints_on;
    logic busy;

    modport dev(
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
        input st_wr, st_addr, st_data, code_addr, ints_on,
        output sfr_rdata, code_rdata, busy
    );
    modport core(
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
        output st_wr, st_addr, st_data, code_addr, ints_on,
        input sfr_rdata, code_rdata, busy
    );
endinterface

/* design/fewc_flash_end.sv */
// flash array with erase and byte write sequencing behind the sfr bus
//
// Functional notes
// - mass erase: enable bit, then 0xAA trigger
// - page erase: load page, then 0x55 trigger
// - mass erase refused without debug port enabled
// - 128 pages of 512 bytes each
// - page bits 7:1 give address 15:9
// - other trigger codes do nothing
// - page address consumed by each page erase
// - mass enable bit 1, consumed, resets 0
// - write enable bit 0 steers stores to flash
// - write enable self clears after each byte
// - write enable frozen while interrupts enabled
// - core disables interrupts before setting enable
// - protect bit 6 set only, reset clears
// - core sets clock divider 0x0C first
// - reset fetch 0x0000, vectors 8 apart from 0x0003
// - program space 0x0000 to 0x7FFF
// - direct upper half sfr, indirect upper ram
// - low 32 bytes: four register banks
// - 16 bytes bit addressable, bits 0x00-0x7F
// - protected page zero: no page erase, no write
`timescale 1ns/1ns
`include "fewc_regs.svh"
module fewc_flash_end
    import fewc_pkg::*;
#(
    parameter int PAGES = `FEWC_PAGES,
    parameter int PAGE_BYTES = `FEWC_PAGE_BYTES,
    parameter int WR_CYCLES = `FEWC_WR_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    fewc_if.dev bus,
    input wire logic dbg_en,
    output logic prot,
    output logic external_data_ram_wr,
    output logic [15:0] external_data_ram_addr,
    output logic [7:0] external_data_ram_data
);
    localparam int AW = $clog2(PAGES * PAGE_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);

    // page register holds seven page bits, so geometry is fixed
    generate
        if (PAGES != 128 || AW != 16 || WR_CYCLES < 1) begin : g_chk
            $error("fewc_flash_end: unsupported geometry or timing");
        end
    endgenerate

    // page zero test shared by the write and the page erase paths
    function automatic logic is_page0(input logic [6:0] p);
        return p == 7'h00;
    endfunction

    fewc_dstate_t st_q, st_d;
    logic dbg_s1_q, dbg_s2_q;
    logic pwe_q, pwe_d;
    logic meen_q, meen_d;
    logic prot_q, prot_d;
    logic loaded_q, loaded_d;
    logic [7:0] page_q, page_d;
    logic [AW-1:0] cnt_q, cnt_d;
    logic [AW-1:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;
    logic busy_q, busy_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] code_q;
    logic xwr_q, xwr_d;
    logic [15:0] xa_q, xa_d;
    logic [7:0] xd_q, xd_d;
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem [0:PAGES*PAGE_BYTES-1];
    logic trig_wr, ctl_wr, page_wr;

    assign trig_wr = bus.sfr_wr && bus.sfr_addr == `FEWC_TRIG_OFS;
    assign ctl_wr = bus.sfr_wr && bus.sfr_addr == `FEWC_CTL_OFS;
    assign page_wr = bus.sfr_wr && bus.sfr_addr == `FEWC_PAGE_OFS;

    // next state of sequencer, control bits and readback
    always_comb begin
        st_d = st_q;
        pwe_d = pwe_q;
        meen_d = meen_q;
        prot_d = prot_q;
        loaded_d = loaded_q;
        page_d = page_q;
        cnt_d = cnt_q;
        wa_d = wa_q;
        wd_d = wd_q;
        rdata_d = rdata_q;
        xwr_d = 1'b0;
        xa_d = xa_q;
        xd_d = xd_q;
        mem_we = 1'b0;
        mem_wa = wa_q;
        mem_wd = wd_q;

        // read data holds until the next read strobe
        if (bus.sfr_rd) begin
            rdata_d = 8'h00;
            case (bus.sfr_addr)
                `FEWC_CTL_OFS: begin
                    rdata_d[`FEWC_PWE_BIT] = pwe_q;
                    rdata_d[`FEWC_PROT_BIT] = prot_q;
                end
                `FEWC_PAGE_OFS: rdata_d = page_q;
                default: rdata_d = 8'h00;
            endcase
        end

        // stores with the enable low always go to data ram
        if (bus.st_wr && !pwe_q) begin
            xwr_d = 1'b1;
            xa_d = bus.st_addr;
            xd_d = bus.st_data;
        end

        case (st_q)
            DS_IDLE: begin
                if (trig_wr && bus.sfr_wdata == `FEWC_CODE_MASS) begin
                    meen_d = 1'b0;
                    if (meen_q && dbg_s2_q) begin
                        st_d = DS_MASS;
                        cnt_d = '0;
                    end
                end else if (trig_wr &&
                             bus.sfr_wdata == `FEWC_CODE_PAGE) begin
                    loaded_d = 1'b0;
                    if (loaded_q && !(prot_q && is_page0(page_q[7:1])))
                    begin
                        st_d = DS_PAGE;
                        cnt_d = '0;
                    end
                end else if (bus.st_wr && pwe_q) begin
                    pwe_d = 1'b0;
                    if (!(prot_q && is_page0(bus.st_addr[15:9]))) begin
                        st_d = DS_WRITE;
                        wa_d = bus.st_addr;
                        wd_d = bus.st_data;
                        cnt_d = '0;
                    end
                end
                // any other trigger value falls through untouched
            end
            DS_PAGE: begin
                mem_we = 1'b1;
                mem_wa = {page_q[7:1], cnt_q[PW-1:0]};
                mem_wd = `FEWC_ERASED;
                cnt_d = cnt_q + AW'(1);
                if (&cnt_q[PW-1:0]) begin
                    st_d = DS_IDLE;
                end
            end
            DS_MASS: begin
                mem_we = 1'b1;
                mem_wa = cnt_q;
                mem_wd = `FEWC_ERASED;
                cnt_d = cnt_q + AW'(1);
                if (&cnt_q) begin
                    st_d = DS_IDLE;
                end
            end
            DS_WRITE: begin
                // byte lands at the end of the write time
                cnt_d = cnt_q + AW'(1);
                if (cnt_q == AW'(WR_CYCLES - 1)) begin
                    mem_we = 1'b1;
                    st_d = DS_IDLE;
                end
            end
            default: st_d = DS_IDLE;
        endcase

        // software writes last so a set beats a hardware clear
        if (ctl_wr) begin
            if (!bus.ints_on) begin
                pwe_d = bus.sfr_wdata[`FEWC_PWE_BIT];
            end
            meen_d = bus.sfr_wdata[`FEWC_MEEN_BIT];
            if (bus.sfr_wdata[`FEWC_PROT_BIT]) begin
                prot_d = 1'b1;
            end
        end
        if (page_wr) begin
            page_d = bus.sfr_wdata;
            loaded_d = 1'b1;
        end
        busy_d = st_d != DS_IDLE;
    end

    // control and sequencer registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= DS_IDLE;
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            pwe_q <= 1'b0;
            meen_q <= 1'b0;
            prot_q <= 1'b0;
            loaded_q <= 1'b0;
            page_q <= `FEWC_PAGE_RST;
            cnt_q <= '0;
            wa_q <= '0;
            wd_q <= 8'h00;
            busy_q <= 1'b0;
            rdata_q <= 8'h00;
            xwr_q <= 1'b0;
            xa_q <= 16'h0000;
            xd_q <= 8'h00;
        end else begin
            st_q <= st_d;
            dbg_s1_q <= dbg_en;
            dbg_s2_q <= dbg_s1_q;
            pwe_q <= pwe_d;
            meen_q <= meen_d;
            prot_q <= prot_d;
            loaded_q <= loaded_d;
            page_q <= page_d;
            cnt_q <= cnt_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            busy_q <= busy_d;
            rdata_q <= rdata_d;
            xwr_q <= xwr_d;
            xa_q <= xa_d;
            xd_q <= xd_d;
        end
    end

    // flash array; contents are not reset, one port writes, one reads
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        code_q <= mem[bus.code_addr];
    end

    assign bus.sfr_rdata = rdata_q;
    assign bus.code_rdata = code_q;
    assign bus.busy = busy_q;
    assign prot = prot_q;
    assign external_data_ram_wr = xwr_q;
    assign external_data_ram_addr = xa_q;
    assign external_data_ram_data = xd_q;
endmodule

/* design/fewc_core_end.sv */
// core end: runs the erase, write, read and fetch sequences on the bus
`timescale 1ns/1ns
`include "fewc_regs.svh"
module fewc_core_end
    import fewc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    fewc_if.core bus,
    input wire logic cmd_valid,
    input wire fewc_op_t cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic ints_req,
    output logic cmd_ready,
    output logic ans_valid,
    output logic [7:0] ans_data,
    output logic ans_sfr,
    output logic ans_err,
    output logic [7:0] div_setting
);
    fewc_hstate_t st_q, st_d;
    fewc_op_t op_q, op_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [7:0] div_q, div_d;
    logic [15:0] pc_q, pc_d;
    logic ints_q, ints_d;
    logic swr_q, swr_d, srd_q, srd_d;
    logic [7:0] sa_q, sa_d, sd_q, sd_d;
    logic stw_q, stw_d;
    logic [15:0] ca_q, ca_d;
    logic rdy_q, rdy_d, av_q, av_d, as_q, as_d, ae_q, ae_d;
    logic [7:0] ad_q, ad_d;

    // next state of the sequence and of every bus strobe
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        div_d = div_q;
        pc_d = pc_q;
        ints_d = ints_q;
        swr_d = 1'b0;
        srd_d = 1'b0;
        stw_d = 1'b0;
        sa_d = sa_q;
        sd_d = sd_q;
        ca_d = ca_q;
        av_d = 1'b0;
        ad_d = ad_q;
        as_d = 1'b0;
        ae_d = 1'b0;
        case (st_q)
            HS_IDLE: begin
                ints_d = ints_req;
                if (cmd_valid && rdy_q) begin
                    op_d = cmd_op;
                    addr_d = cmd_addr;
                    data_d = cmd_data;
                    st_d = HS_ST1;
                    case (cmd_op)
                        OP_DIV: begin
                            div_d = cmd_data;
                            av_d = 1'b1;
                            st_d = HS_IDLE;
                        end
                        OP_VEC: begin
                            pc_d = fewc_vec_addr(cmd_data);
                            av_d = 1'b1;
                            st_d = HS_IDLE;
                        end
                        OP_INTERNAL_DATA_RAM: begin
                            {as_d, ad_d} = fewc_internal_data_ram_map(cmd_data[1:0],
                                cmd_addr[7:0], cmd_data[3:2]);
                            av_d = 1'b1;
                            st_d = HS_IDLE;
                        end
                        OP_FETCH: begin
                            if (pc_q > `FEWC_CODE_TOP) begin
                                ae_d = 1'b1;
                                av_d = 1'b1;
                                st_d = HS_IDLE;
                            end else begin
                                ca_d = pc_q;
                                pc_d = 16'(pc_q + 16'h0001);
                            end
                        end
                        OP_PAGE, OP_MASS, OP_WRITE: begin
                            // wrong clock setting would corrupt flash timing
                            if (div_q != `FEWC_DIV_FLASH) begin
                                ae_d = 1'b1;
                                av_d = 1'b1;
                                st_d = HS_IDLE;
                            end else if (cmd_op == OP_WRITE) begin
                                ints_d = 1'b0;
                            end
                        end
                        default: st_d = HS_ST1;
                    endcase
                end
            end
            HS_ST1: begin
                st_d = HS_ST2;
                case (op_q)
                    OP_PAGE: begin
                        swr_d = 1'b1;
                        sa_d = `FEWC_PAGE_OFS;
                        sd_d = data_q;
                    end
                    OP_MASS: begin
                        swr_d = 1'b1;
                        sa_d = `FEWC_CTL_OFS;
                        sd_d = 8'h00;
                        sd_d[`FEWC_MEEN_BIT] = 1'b1;
                    end
                    OP_WRITE: begin
                        swr_d = 1'b1;
                        sa_d = `FEWC_CTL_OFS;
                        sd_d = 8'h00;
                        sd_d[`FEWC_PWE_BIT] = 1'b1;
                    end
                    OP_WSFR: begin
                        swr_d = 1'b1;
                        sa_d = addr_q[7:0];
                        sd_d = data_q;
                    end
                    OP_RSFR: begin
                        srd_d = 1'b1;
                        sa_d = addr_q[7:0];
                    end
                    default: srd_d = 1'b0;
                endcase
            end
            HS_ST2: begin
                st_d = HS_GAP;
                if (op_q == OP_PAGE || op_q == OP_MASS) begin
                    swr_d = 1'b1;
                    sa_d = `FEWC_TRIG_OFS;
                    sd_d = op_q == OP_PAGE ? `FEWC_CODE_PAGE
                                           : `FEWC_CODE_MASS;
                end else if (op_q == OP_WRITE) begin
                    stw_d = 1'b1;
                end
            end
            // one idle cycle so the flash busy flag has settled
            HS_GAP: st_d = HS_WAIT;
            HS_WAIT: begin
                if (!bus.busy) begin
                    st_d = HS_IDLE;
                    av_d = 1'b1;
                    ints_d = ints_req;
                    ad_d = op_q == OP_RSFR ? bus.sfr_rdata :
                           op_q == OP_FETCH ? bus.code_rdata : 8'h00;
                end
            end
            default: st_d = HS_IDLE;
        endcase
        rdy_d = st_d == HS_IDLE;
    end

    // sequence state and registered bus drive
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= HS_IDLE;
            op_q <= OP_DIV;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            div_q <= `FEWC_DIV_RST;
            pc_q <= `FEWC_RESET_PC;
            ints_q <= 1'b0;
            swr_q <= 1'b0;
            srd_q <= 1'b0;
            stw_q <= 1'b0;
            sa_q <= 8'h00;
            sd_q <= 8'h00;
            ca_q <= 16'h0000;
            rdy_q <= 1'b0;
            av_q <= 1'b0;
            ad_q <= 8'h00;
            as_q <= 1'b0;
            ae_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            div_q <= div_d;
            pc_q <= pc_d;
            ints_q <= ints_d;
            swr_q <= swr_d;
            srd_q <= srd_d;
            stw_q <= stw_d;
            sa_q <= sa_d;
            sd_q <= sd_d;
            ca_q <= ca_d;
            rdy_q <= rdy_d;
            av_q <= av_d;
            ad_q <= ad_d;
            as_q <= as_d;
            ae_q <= ae_d;
        end
    end

    assign bus.sfr_wr = swr_q;
    assign bus.sfr_rd = srd_q;
    assign bus.sfr_addr = sa_q;
    assign bus.sfr_wdata = sd_q;
    assign bus.st_wr = stw_q;
    assign bus.st_addr = addr_q;
    assign bus.st_data = data_q;
    assign bus.code_addr = ca_q;
    assign bus.ints_on = ints_q;
    assign cmd_ready = rdy_q;
    assign ans_valid = av_q;
    assign ans_data = ad_q;
    assign ans_sfr = as_q;
    assign ans_err = ae_q;
    assign div_setting = div_q;
endmodule

/* verif/fewc_chk_sva.sv */
// bus checks between the core end and the flash end
`timescale 1ns/1ns
`include "fewc_regs.svh"
module fewc_chk
    import fewc_pkg::*;
#(
    parameter int PAGES = `FEWC_PAGES,
    parameter int PAGE_BYTES = `FEWC_PAGE_BYTES,
    parameter int WR_CYCLES = `FEWC_WR_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic st_wr,
    input wire logic ints_on,
    input wire logic busy
);
    logic [16:0] run_q, run_d;
    logic [1:0] kind_q, kind_d;
    logic trig;
    assign trig = sfr_wr && sfr_addr == `FEWC_TRIG_OFS;
    // length of a busy run and what launched it; last launch wins
    always_comb begin
        run_d = busy ? run_q + 17'h1 : 17'h0;
        kind_d = kind_q;
        if (st_wr) begin
            kind_d = 2'h1;
        end else if (trig && sfr_wdata == `FEWC_CODE_PAGE) begin
            kind_d = 2'h2;
        end else if (trig && sfr_wdata == `FEWC_CODE_MASS) begin
            kind_d = 2'h3;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_q <= 17'h0;
            kind_q <= 2'h0;
        end else begin
            run_q <= run_d;
            kind_q <= kind_d;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_odd_code: assert property (
        trig && !busy && sfr_wdata != `FEWC_CODE_MASS
        && sfr_wdata != `FEWC_CODE_PAGE |=> !busy)
        else $error("busy after unknown trigger code");
    chk_busy_cause: assert property (
        $rose(busy) |-> $past(trig) || $past(st_wr))
        else $error("busy rose without trigger or store");
    chk_write_len: assert property (
        $fell(busy) && kind_q == 2'h1 |-> run_q == 17'(WR_CYCLES))
        else $error("byte write length wrong");
    chk_page_len: assert property (
        $fell(busy) && kind_q == 2'h2 |-> run_q == 17'(PAGE_BYTES))
        else $error("page erase length wrong");
    chk_mass_len: assert property (
        $fell(busy) && kind_q == 2'h3 |-> run_q == 17'(PAGES * PAGE_BYTES))
        else $error("mass erase length wrong");
    chk_store_idle: assert property (
        st_wr |-> !busy && !ints_on)
        else $error("store while busy or interrupts on");
    chk_ctl_read: assert property (
        sfr_rd && sfr_addr == `FEWC_CTL_OFS |=> !sfr_rdata[`FEWC_MEEN_BIT])
        else $error("mass enable bit read back set");
    chk_trig_read: assert property (
        sfr_rd && sfr_addr == `FEWC_TRIG_OFS |=> sfr_rdata == 8'h00)
        else $error("trigger register read not zero");
    cov_write: cover property ($fell(busy) && kind_q == 2'h1);
    cov_page: cover property ($fell(busy) && kind_q == 2'h2);
    cov_mass: cover property ($fell(busy) && kind_q == 2'h3);
endmodule

/* verif/tb.sv */
// self-checking bench for the two ends joined by their bus
`timescale 1ns/1ns
`include "fewc_regs.svh"
module tb;
    import fewc_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic dbg_en = 1'b0;
    logic cmd_valid = 1'b0;
    fewc_op_t cmd_op = OP_DIV;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic ints_req = 1'b0;
    logic cmd_ready, ans_valid, ans_sfr, ans_err, prot, r_sfr, r_err;
    logic [7:0] ans_data, div_setting, r_data, external_data_ram_data;
    logic [15:0] external_data_ram_addr;
    logic external_data_ram_wr;
    int n_errors = 0;
    int checks = 0;
    int nbusy = 0;
    int nxram = 0;
    int cyc = 0;
    fewc_if u_fewc_if();
    fewc_flash_end u_fewc_flash_end(.mclk(mclk), .sys_rst(sys_rst),
        .bus(u_fewc_if.dev), .dbg_en(dbg_en), .prot(prot),
        .external_data_ram_wr(external_data_ram_wr), .external_data_ram_addr(external_data_ram_addr), .external_data_ram_data(external_data_ram_data));
    fewc_core_end u_fewc_core_end(.mclk(mclk), .sys_rst(sys_rst),
        .bus(u_fewc_if.core), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .ints_req(ints_req),
        .cmd_ready(cmd_ready), .ans_valid(ans_valid), .ans_data(ans_data),
        .ans_sfr(ans_sfr), .ans_err(ans_err), .div_setting(div_setting));
    fewc_chk u_fewc_chk(.mclk(mclk), .sys_rst(sys_rst),
        .sfr_wr(u_fewc_if.sfr_wr), .sfr_rd(u_fewc_if.sfr_rd),
        .sfr_addr(u_fewc_if.sfr_addr), .sfr_wdata(u_fewc_if.sfr_wdata),
        .sfr_rdata(u_fewc_if.sfr_rdata), .st_wr(u_fewc_if.st_wr),
        .ints_on(u_fewc_if.ints_on), .busy(u_fewc_if.busy));
    always #25 mclk = ~mclk;
    // busy cycle count stands in for watching every erase by hand
    // sampled mid-cycle, away from the edge that moves busy
    always @(negedge mclk) begin
        cyc++;
        if (u_fewc_if.busy === 1'b1) begin
            nbusy++;
        end
        if (external_data_ram_wr === 1'b1) begin
            nxram++;
        end
        if (cyc == 80000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic do_reset();
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
    endtask
    // request held from a falling edge until a rising edge with ready high
    task automatic cmd(fewc_op_t op, logic [15:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        while (cmd_ready !== 1'b1) begin
            @(negedge mclk);
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (ans_valid !== 1'b1 && n < 70000) begin
            @(negedge mclk);
            n++;
        end
        // a command that never answers ends the run as a failure
        if (n >= 70000) begin
            n_errors++;
            finish_test();
        end
        r_data = ans_data;
        r_sfr = ans_sfr;
        r_err = ans_err;
    endtask
    task automatic fetch(logic [7:0] n);
        cmd(OP_VEC, {8'h00, n}, n);
        cmd(OP_FETCH, 16'h0000, 8'h00);
    endtask
    task automatic internal_data_ram(logic [7:0] a, logic [7:0] d, logic [8:0] e);
        cmd(OP_INTERNAL_DATA_RAM, {8'h00, a}, d);
        chk("internal_data_ram map", {r_sfr, r_data}, e);
    endtask
    task automatic t_divider();
        cmd(OP_PAGE, 16'h0000, 8'h02);
        chk("slow clock refused", r_err, 1'b1);
        cmd(OP_DIV, 16'h0000, `FEWC_DIV_FLASH);
        chk("divider", div_setting, `FEWC_DIV_FLASH);
    endtask
    task automatic t_mass();
        int b;
        b = nbusy;
        cmd(OP_MASS, 16'h0000, 8'h00);
        chk("mass without debug", nbusy - b, 0);
        dbg_en = 1'b1;
        repeat (3) @(negedge mclk);
        cmd(OP_MASS, 16'h0000, 8'h00);
        chk("mass busy", nbusy - b, 65536);
        fetch(8'h00);
        chk("erased", r_data, `FEWC_ERASED);
        b = nbusy;
        cmd(OP_WSFR, 16'h0094, `FEWC_CODE_MASS);
        chk("enable consumed", nbusy - b, 0);
    endtask
    task automatic t_write();
        int b;
        b = nbusy;
        cmd(OP_WRITE, 16'h0203, 8'h5A);
        cmd(OP_WRITE, 16'h0403, 8'hC3);
        chk("write busy", nbusy - b, 2 * `FEWC_WR_CYCLES);
        chk("data ram stores", nxram, 0);
        chk("data ram bus", {external_data_ram_addr, external_data_ram_data}, 24'h000000);
        fetch(8'd64);
        chk("byte in flash", r_data, 8'h5A);
        cmd(OP_RSFR, 16'h00B2, 8'h00);
        chk("write enable cleared", r_data[0], 1'b0);
        cmd(OP_RSFR, 16'h0094, 8'h00);
        chk("trigger reads zero", r_data, 8'h00);
    endtask
    task automatic t_page();
        int b;
        logic [7:0] odd [5];
        odd = '{8'h00, 8'hFF, 8'h54, 8'hAB, 8'h5A};
        b = nbusy;
        cmd(OP_PAGE, 16'h0000, 8'h03); // bit 0 set, must not matter
        chk("page busy", nbusy - b, 512);
        fetch(8'd64);
        chk("page erased", r_data, `FEWC_ERASED);
        fetch(8'd128);
        chk("next page kept", r_data, 8'hC3);
        cmd(OP_WRITE, 16'h0203, 8'h77);
        b = nbusy;
        cmd(OP_WSFR, 16'h0094, `FEWC_CODE_PAGE);
        chk("stale page load", nbusy - b, 0);
        foreach (odd[i]) begin
            cmd(OP_WSFR, 16'h0094, odd[i]);
        end
        chk("other codes", nbusy - b, 0);
        fetch(8'd64);
        chk("byte kept", r_data, 8'h77);
    endtask
    task automatic t_ints();
        ints_req = 1'b1;
        repeat (2) @(negedge mclk);
        cmd(OP_WSFR, 16'h00B2, 8'h01);
        cmd(OP_RSFR, 16'h00B2, 8'h00);
        chk("enable frozen", r_data[0], 1'b0);
        ints_req = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic t_prot();
        int b;
        cmd(OP_WRITE, 16'h0000, 8'h3C);
        cmd(OP_WSFR, 16'h00B2, 8'h40);
        chk("protect set", prot, 1'b1);
        cmd(OP_WSFR, 16'h00B2, 8'h00);
        chk("protect sticky", prot, 1'b1);
        cmd(OP_WRITE, 16'h0003, 8'h11);
        b = nbusy;
        cmd(OP_PAGE, 16'h0000, 8'h00);
        chk("page zero erase", nbusy - b, 0);
        fetch(8'h00);
        chk("page zero write", r_data, `FEWC_ERASED);
        do_reset();
        chk("protect cleared", prot, 1'b0);
        cmd(OP_FETCH, 16'h0000, 8'h00);
        chk("reset fetch", r_data, 8'h3C);
    endtask
    // flash is not reset, so the mass erase comes before any write
    initial begin
        do_reset();
        t_divider();
        t_mass();
        t_write();
        t_page();
        t_ints();
        internal_data_ram(8'h90, 8'h00, 9'h190);
        internal_data_ram(8'h90, 8'h01, 9'h090);
        internal_data_ram(8'h05, 8'h0A, 9'h015);
        internal_data_ram(8'h0B, 8'h03, 9'h021);
        t_prot();
        finish_test();
    end
endmodule
